//--- verilog/uart_cfg_pkg.sv
// Shared constants and carrier types for one serial channel's setup block.
// Assumes a 32-bit AXI4-Lite register port, one register per aligned word.
package uart_cfg_pkg;
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] OFS_FIFO_SETUP = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_LINE = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_MODEM = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_ENH = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_FEAT = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_TRG = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_ALT = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_DATA = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_DIV_HIGH = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_DIV_FRAC = 6'h28;
	localparam int FS_ENABLE = 0;
	localparam int FS_RX_RESET = 1;
	localparam int FS_TX_RESET = 2;
	localparam int FS_DMA = 3;
	localparam int FS_TX_TRIG = 4;
	localparam int FS_RX_TRIG = 6;
	localparam int LF_STOP = 2;
	localparam int LF_PAR_EN = 3;
	localparam int LF_PAR_EVEN = 4;
	localparam int LF_PAR_FORCE = 5;
	localparam int LF_BREAK = 6;
	localparam int LF_DIV_ACCESS = 7;
	localparam int MO_TERM_READY = 0;
	localparam int MO_REQ_SEND = 1;
	localparam int MO_BELL_LOOP = 2;
	localparam int MO_USER_TWO = 3;
	localparam int MO_LOOPBACK = 4;
	localparam int MO_XON_ANY = 5;
	localparam int EF_ENHANCED = 4;
	localparam int FC_TABLE = 4;
	localparam int FC_TRG_TX = 7;
	localparam int AF_FUNC = 1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] TRG_RESET = 8'h01;
	localparam logic [1:0] TBL_A = 2'h0;
	localparam logic [1:0] TBL_B = 2'h1;
	localparam logic [1:0] TBL_C = 2'h2;
	localparam logic [1:0] AF_USER_PIN = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] WL_FIVE = 2'h0;
	localparam logic [3:0] WL_BASE = 4'h5;
	localparam logic [2:0] STOP_ONE = 3'h2;
	localparam logic [2:0] STOP_ONE_HALF = 3'h3;
	localparam logic [2:0] STOP_TWO = 3'h4;
	// Index by select code; element 0 is the select code 00 level
	localparam logic [3:0][7:0] RX_TRIG_A = {8'h0e, 8'h08, 8'h04, 8'h01};
	localparam logic [3:0][7:0] RX_TRIG_B = {8'h1c, 8'h18, 8'h10, 8'h08};
	localparam logic [3:0][7:0] RX_TRIG_C = {8'h3c, 8'h38, 8'h10, 8'h08};
	localparam logic [7:0] TX_TRIG_A = 8'h01;
	localparam logic [3:0][7:0] TX_TRIG_B = {8'h1e, 8'h18, 8'h08, 8'h10};
	localparam logic [3:0][7:0] TX_TRIG_C = {8'h38, 8'h20, 8'h10, 8'h08};
	typedef struct packed {
		logic [3:0] word_bits;
		logic [2:0] stop_halves;
		logic parity_en;
		logic parity_even;
		logic parity_forced;
		logic break_hold;
	} line_cfg_t;
	typedef struct packed {
		logic term_ready_n;
		logic req_send_n;
		logic user_output_two_n;
	} modem_pins_t;
endpackage

//--- verilog/uart_fifo_line_modem_control.sv
// FIFO setup, line format and modem output control for one serial channel.
// Assumes the FIFO storage, shifters and baud generator sit outside on aclk.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module uart_fifo_line_modem_control #(
	parameter int FIFO_DEPTH = 64,
	parameter int LVL_W = $clog2(FIFO_DEPTH + 1)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [uart_cfg_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [uart_cfg_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char,
	input wire logic rx_parity_bit,
	input wire logic rx_is_flow_char,
	input wire logic sw_flow_active,
	input wire logic [7:0] rx_head,
	input wire logic [7:0] tx_char,
	input wire logic tx_char_sent,
	input wire logic tx_serial,
	input wire logic auto_rts_en,
	input wire logic auto_rts_n,
	input wire logic bell_signal_in_n,
	input wire logic carrier_detect_in_n,
	output logic rx_store,
	output logic rx_parity_error,
	output logic resume_tx,
	output logic rx_pop,
	output logic tx_push,
	output logic [7:0] tx_data,
	output logic tx_parity,
	output logic tx_line,
	output logic rx_flush,
	output logic tx_flush,
	output logic fifo_enable,
	output logic rx_request,
	output logic tx_request,
	output logic receive_ready_pin_n,
	output logic transmit_ready_pin_n,
	output uart_cfg_pkg::line_cfg_t line_cfg,
	output uart_cfg_pkg::modem_pins_t modem_pins,
	output logic loopback,
	output logic [15:0] divisor,
	output logic [7:0] divisor_fraction
);
	import uart_cfg_pkg::*;

	logic [7:0] line_format_reg;
	logic [7:0] modem_outputs_reg;
	logic [7:0] enhanced_feature_reg;
	logic [7:0] feature_control_reg;
	logic [7:0] alternate_function_reg;
	logic [7:0] rx_trig_user;
	logic [7:0] tx_trig_user;
	logic [1:0] rx_sel;
	logic [1:0] tx_sel;
	logic dma_mode;
	logic [LVL_W-1:0] rx_count;
	logic [LVL_W-1:0] tx_count;
	logic tx_filled_above;
	logic [1:0] bell_sync;
	logic [1:0] carrier_sync;
	logic wr_go;
	logic rd_go;
	logic [7:0] wbyte;
	logic wr_ok;
	logic rd_ok;
	logic [31:0] next_rdata;
	logic [7:0] rx_level;
	logic [7:0] tx_level;
	logic bell_state;
	logic carrier_state;

	// Decoding shared by the write and read paths
	function automatic logic mapped(input logic [ADDR_W-1:0] a, input logic div_acc);
		case (a)
			OFS_FIFO_SETUP, OFS_LINE, OFS_MODEM, OFS_ENH, OFS_FEAT,
			OFS_TRG, OFS_ALT, OFS_STATUS, OFS_DATA: mapped = 1'b1;
			OFS_DIV_HIGH, OFS_DIV_FRAC: mapped = div_acc;
			default: mapped = 1'b0;
		endcase
	endfunction

	// Parity for a character under the current format
	function automatic logic parity_of(input logic [7:0] c, input logic [7:0] lf);
		logic [7:0] mask;
		logic ones;
		mask = 8'hff >> (2'h3 - lf[1:0]);
		ones = ^(c & mask);
		if (lf[LF_PAR_FORCE]) begin
			parity_of = ~lf[LF_PAR_EVEN];
		end else begin
			parity_of = lf[LF_PAR_EVEN] ? ones : ~ones;
		end
	endfunction

	// Both channels taken in one edge keeps the write path free of holding registers
	assign awready = awvalid & wvalid & ~bvalid;
	assign wready = awready;
	assign wr_go = awready;
	assign arready = ~rvalid;
	assign rd_go = arvalid & arready;
	assign wbyte = wdata[7:0];
	assign wr_ok = mapped(awaddr, line_format_reg[LF_DIV_ACCESS]);
	assign rd_ok = mapped(araddr, line_format_reg[LF_DIV_ACCESS]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= '0;
		end else if (rd_go) begin
			rvalid <= 1'b1;
			rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			rdata <= rd_ok ? next_rdata : '0;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	always_comb begin
		next_rdata = '0;
		case (araddr)
			OFS_LINE: next_rdata[7:0] = line_format_reg;
			OFS_MODEM: next_rdata[7:0] = modem_outputs_reg;
			OFS_ENH: next_rdata[7:0] = enhanced_feature_reg;
			OFS_FEAT: next_rdata[7:0] = feature_control_reg;
			OFS_ALT: next_rdata[7:0] = alternate_function_reg;
			OFS_STATUS: next_rdata = {12'h000, fifo_enable, carrier_state, bell_state,
				dma_mode, 8'(tx_count), 8'(rx_count)};
			OFS_DATA: next_rdata[7:0] = line_format_reg[LF_DIV_ACCESS] ? divisor[7:0] : rx_head;
			OFS_DIV_HIGH: next_rdata[7:0] = divisor[15:8];
			OFS_DIV_FRAC: next_rdata[7:0] = divisor_fraction;
			default: next_rdata = '0;
		endcase
	end

	// Data register accesses move characters only while the divisors are hidden
	assign tx_push = wr_go && wstrb[0] && awaddr == OFS_DATA && !line_format_reg[LF_DIV_ACCESS];
	assign rx_pop = rd_go && araddr == OFS_DATA && !line_format_reg[LF_DIV_ACCESS];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_data <= REG_RESET;
		end else if (tx_push) begin
			tx_data <= wbyte;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			divisor <= '0;
			divisor_fraction <= REG_RESET;
		end else if (wr_go && wstrb[0] && line_format_reg[LF_DIV_ACCESS]) begin
			if (awaddr == OFS_DATA) begin
				divisor[7:0] <= wbyte;
			end
			if (awaddr == OFS_DIV_HIGH) begin
				divisor[15:8] <= wbyte;
			end
			if (awaddr == OFS_DIV_FRAC) begin
				divisor_fraction <= wbyte;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_format_reg <= REG_RESET;
			modem_outputs_reg <= REG_RESET;
			enhanced_feature_reg <= REG_RESET;
			feature_control_reg <= REG_RESET;
			alternate_function_reg <= REG_RESET;
		end else if (wr_go && wstrb[0]) begin
			if (awaddr == OFS_LINE) begin
				line_format_reg <= wbyte;
			end
			if (awaddr == OFS_MODEM) begin
				modem_outputs_reg <= wbyte;
			end
			if (awaddr == OFS_ENH) begin
				enhanced_feature_reg <= wbyte;
			end
			if (awaddr == OFS_FEAT) begin
				feature_control_reg <= wbyte;
			end
			if (awaddr == OFS_ALT) begin
				alternate_function_reg <= wbyte;
			end
		end
	end

	// Trigger-level register lands in one of two slots by the direction bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_trig_user <= TRG_RESET;
			tx_trig_user <= TRG_RESET;
		end else if (wr_go && wstrb[0] && awaddr == OFS_TRG) begin
			if (feature_control_reg[FC_TRG_TX]) begin
				tx_trig_user <= wbyte;
			end else begin
				rx_trig_user <= wbyte;
			end
		end
	end

	// Fields program only when the same write sets the enable bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifo_enable <= 1'b0;
			dma_mode <= 1'b0;
			rx_sel <= 2'h0;
			tx_sel <= 2'h0;
		end else if (wr_go && wstrb[0] && awaddr == OFS_FIFO_SETUP) begin
			fifo_enable <= wbyte[FS_ENABLE];
			if (wbyte[FS_ENABLE]) begin
				dma_mode <= wbyte[FS_DMA];
				rx_sel <= wbyte[FS_RX_TRIG +: 2];
				if (enhanced_feature_reg[EF_ENHANCED]) begin
					tx_sel <= wbyte[FS_TX_TRIG +: 2];
				end
			end
		end
	end

	// Reset bits are never stored, so they always read back as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_flush <= 1'b0;
			tx_flush <= 1'b0;
		end else begin
			rx_flush <= wr_go && wstrb[0] && awaddr == OFS_FIFO_SETUP
				&& wbyte[FS_ENABLE] && wbyte[FS_RX_RESET];
			tx_flush <= wr_go && wstrb[0] && awaddr == OFS_FIFO_SETUP
				&& wbyte[FS_ENABLE] && wbyte[FS_TX_RESET];
		end
	end

	// Trigger tables; table D ignores the select fields
	always_comb begin
		unique case (feature_control_reg[FC_TABLE +: 2])
			TBL_A: begin
				rx_level = RX_TRIG_A[rx_sel];
				tx_level = TX_TRIG_A;
			end
			TBL_B: begin
				rx_level = RX_TRIG_B[rx_sel];
				tx_level = TX_TRIG_B[tx_sel];
			end
			TBL_C: begin
				rx_level = RX_TRIG_C[rx_sel];
				tx_level = TX_TRIG_C[tx_sel];
			end
			default: begin
				rx_level = rx_trig_user;
				tx_level = tx_trig_user;
			end
		endcase
	end

	// Level counters; the flush wins, shift registers outside are untouched
	always_ff @(posedge aclk) begin
		if (!aresetn || rx_flush) begin
			rx_count <= '0;
		end else begin
			rx_count <= rx_count + LVL_W'(rx_store && rx_count != LVL_W'(FIFO_DEPTH))
				- LVL_W'(rx_pop && rx_count != '0);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || tx_flush) begin
			tx_count <= '0;
		end else begin
			tx_count <= tx_count + LVL_W'(tx_push && tx_count != LVL_W'(FIFO_DEPTH))
				- LVL_W'(tx_char_sent && tx_count != '0);
		end
	end

	// Remembers whether the current reload went above the trigger
	always_ff @(posedge aclk) begin
		if (!aresetn || tx_flush) begin
			tx_filled_above <= 1'b0;
		end else if (tx_count == '0) begin
			tx_filled_above <= 1'b0;
		end else if (8'(tx_count) > tx_level) begin
			tx_filled_above <= 1'b1;
		end
	end

	assign rx_request = fifo_enable && 8'(rx_count) >= rx_level;
	assign tx_request = fifo_enable && (tx_filled_above ? 8'(tx_count) < tx_level
		: tx_count == '0);

	// Normal mode signals one character / empty; DMA mode signals trigger / room
	always_comb begin
		if (dma_mode) begin
			receive_ready_pin_n = ~rx_request;
			transmit_ready_pin_n = tx_count == LVL_W'(FIFO_DEPTH);
		end else begin
			receive_ready_pin_n = rx_count == '0;
			transmit_ready_pin_n = tx_count != '0;
		end
	end

	always_comb begin
		line_cfg.word_bits = WL_BASE + {2'h0, line_format_reg[1:0]};
		if (!line_format_reg[LF_STOP]) begin
			line_cfg.stop_halves = STOP_ONE;
		end else begin
			line_cfg.stop_halves = line_format_reg[1:0] == WL_FIVE ? STOP_ONE_HALF : STOP_TWO;
		end
		line_cfg.parity_en = line_format_reg[LF_PAR_EN];
		line_cfg.parity_even = line_format_reg[LF_PAR_EVEN];
		line_cfg.parity_forced = line_format_reg[LF_PAR_FORCE];
		line_cfg.break_hold = line_format_reg[LF_BREAK];
	end

	assign tx_parity = parity_of(tx_char, line_format_reg);
	assign rx_parity_error = rx_char_valid && line_format_reg[LF_PAR_EN]
		&& rx_parity_bit != parity_of(rx_char, line_format_reg);
	assign tx_line = tx_serial & ~line_format_reg[LF_BREAK];

	// Flow characters are consumed only while software flow control runs
	assign rx_store = rx_char_valid && !(rx_is_flow_char && sw_flow_active);
	assign resume_tx = rx_char_valid && modem_outputs_reg[MO_XON_ANY]
		&& enhanced_feature_reg[EF_ENHANCED];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bell_sync <= 2'h3;
			carrier_sync <= 2'h3;
		end else begin
			bell_sync <= {bell_sync[0], bell_signal_in_n};
			carrier_sync <= {carrier_sync[0], carrier_detect_in_n};
		end
	end

	assign loopback = modem_outputs_reg[MO_LOOPBACK];
	assign bell_state = loopback ? modem_outputs_reg[MO_BELL_LOOP] : ~bell_sync[1];
	assign carrier_state = loopback ? modem_outputs_reg[MO_USER_TWO] : ~carrier_sync[1];

	// Pins idle high in loopback so the far end sees no activity
	always_comb begin
		modem_pins.term_ready_n = loopback | ~modem_outputs_reg[MO_TERM_READY];
		if (auto_rts_en) begin
			modem_pins.req_send_n = loopback | auto_rts_n;
		end else begin
			modem_pins.req_send_n = loopback | ~modem_outputs_reg[MO_REQ_SEND];
		end
		modem_pins.user_output_two_n = loopback
			| alternate_function_reg[AF_FUNC +: 2] != AF_USER_PIN
			| ~modem_outputs_reg[MO_USER_TWO];
	end
endmodule

//--- sim/uart_cfg_checker.sv
// Port-level checks for the serial channel setup block.
// Assumes binding onto the block's top module; single aclk domain.
`timescale 1ns/1ps
module uart_cfg_checker
	import uart_cfg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [uart_cfg_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic tx_serial,
	input wire logic tx_line,
	input wire logic tx_parity,
	input wire logic rx_flush,
	input wire logic tx_flush,
	input wire uart_cfg_pkg::line_cfg_t line_cfg,
	input wire uart_cfg_pkg::modem_pins_t modem_pins,
	input wire logic loopback,
	input wire logic auto_rts_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Only writes with lane 0 enabled change anything
	wire logic wr_ok = awvalid && awready && wstrb[0];
	wire logic wr_line = wr_ok && awaddr == OFS_LINE;
	wire logic wr_fifo = wr_ok && awaddr == OFS_FIFO_SETUP;
	wire logic wr_modem = wr_ok && awaddr == OFS_MODEM;
	a_word_len: assert property (
		wr_line |=> line_cfg.word_bits == WL_BASE + $past(wdata[1:0]))
		else $error("word length not taken from write");
	a_stop_len: assert property (
		wr_line |=> line_cfg.stop_halves == (!$past(wdata[2]) ? STOP_ONE :
			($past(wdata[1:0]) == WL_FIVE ? STOP_ONE_HALF : STOP_TWO)))
		else $error("stop length wrong");
	a_parity_bits: assert property (
		wr_line |=> {line_cfg.parity_en, line_cfg.parity_even, line_cfg.parity_forced}
			== {$past(wdata[3]), $past(wdata[4]), $past(wdata[5])})
		else $error("parity setup wrong");
	a_forced_par: assert property (
		line_cfg.parity_en && line_cfg.parity_forced |-> tx_parity == !line_cfg.parity_even)
		else $error("forced parity level wrong");
	a_break_low: assert property (
		wr_line |=> line_cfg.break_hold == $past(wdata[6])
			&& tx_line == (tx_serial && !$past(wdata[6])))
		else $error("break does not hold line low");
	a_rx_flush: assert property (
		wr_fifo |=> (rx_flush == $past(wdata[0] && wdata[1])) ##1 !rx_flush)
		else $error("receive flush pulse wrong");
	a_tx_flush: assert property (
		wr_fifo |=> (tx_flush == $past(wdata[0] && wdata[2])) ##1 !tx_flush)
		else $error("transmit flush pulse wrong");
	a_term_ready: assert property (
		wr_modem && !wdata[4] |=> modem_pins.term_ready_n == !$past(wdata[0]))
		else $error("terminal ready pin wrong");
	a_req_send: assert property (
		wr_modem && !wdata[4] |=> auto_rts_en || modem_pins.req_send_n == !$past(wdata[1]))
		else $error("request to send pin wrong");
	a_loop_en: assert property (
		wr_modem |=> loopback == $past(wdata[4]))
		else $error("loopback enable wrong");
	cover property (wr_fifo && wdata[0] && wdata[1]);
	cover property (line_cfg.break_hold);
	cover property (loopback);
endmodule

//--- sim/uart_line_peer.sv
// Far side of the channel: line deserialiser and transmit shifter stand-in.
// Assumes the testbench calls send and take between register accesses.
`timescale 1ns/1ps
module uart_line_peer (
	input wire logic aclk,
	output logic rx_char_valid,
	output logic [7:0] rx_char,
	output logic rx_parity_bit,
	output logic rx_is_flow_char,
	output logic sw_flow_active,
	output logic [7:0] rx_head,
	output logic [7:0] tx_char,
	output logic tx_char_sent,
	output logic tx_serial,
	output logic auto_rts_en,
	output logic auto_rts_n,
	output logic bell_signal_in_n,
	output logic carrier_detect_in_n
);
	// Idle line is mark; modem inputs inactive high
	initial begin
		{rx_char_valid, rx_char, rx_parity_bit, rx_is_flow_char, sw_flow_active} = '0;
		{rx_head, tx_char, tx_char_sent, auto_rts_en} = '0;
		{tx_serial, auto_rts_n, bell_signal_in_n, carrier_detect_in_n} = 4'hf;
	end
	task send(input int n);
		repeat (n) begin
			@(posedge aclk);
			rx_char_valid <= 1'b1;
			rx_char <= rx_char + 8'h01;
		end
		@(posedge aclk);
		rx_char_valid <= 1'b0;
		@(negedge aclk);
	endtask
	// One character held from a rising edge; send(0) drops it again
	task put(input logic [7:0] c, input logic p, input logic f, input logic s);
		@(posedge aclk);
		rx_char_valid <= 1'b1;
		rx_char <= c;
		tx_char <= c;
		rx_parity_bit <= p;
		rx_is_flow_char <= f;
		sw_flow_active <= s;
		@(negedge aclk);
	endtask
	task take(input int n);
		repeat (n) begin
			@(posedge aclk);
			tx_char_sent <= 1'b1;
		end
		@(posedge aclk);
		tx_char_sent <= 1'b0;
		@(negedge aclk);
	endtask
endmodule

//--- sim/uart_fifo_line_modem_control_test.sv
// Self-checking bench: register accesses over AXI4-Lite plus line traffic.
// Assumes the peer model drives every line-side input of the block.
`timescale 1ns/1ps
module uart_fifo_line_modem_control_test;
	import uart_cfg_pkg::*;
	localparam logic [1:0] TBL [13] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
		2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
	localparam logic [1:0] CODE [13] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3,
		2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	localparam int LVL [13] = '{1, 4, 8, 14, 8, 16, 24, 28, 8, 16, 56, 60, 3};
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	// Ready lines held high: the bench always accepts answers at once
	logic bready = 1, rready = 1;
	logic awready, wready, bvalid, arready, rvalid, rx_store, rx_parity_error, resume_tx;
	logic rx_pop, tx_push, tx_parity, tx_line, rx_flush, tx_flush, fifo_enable, loopback;
	logic rx_request, tx_request, receive_ready_pin_n, transmit_ready_pin_n, rx_char_valid;
	logic rx_parity_bit, rx_is_flow_char, sw_flow_active, tx_char_sent, tx_serial;
	logic auto_rts_en, auto_rts_n, bell_signal_in_n, carrier_detect_in_n;
	logic [5:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp;
	logic [7:0] rx_char, rx_head, tx_char, tx_data, divisor_fraction;
	logic [15:0] divisor;
	line_cfg_t line_cfg;
	modem_pins_t modem_pins;
	int error_cnt = 0, n_checks = 0;
	always #25 aclk = ~aclk;
	uart_fifo_line_modem_control uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .rx_char_valid, .rx_char, .rx_parity_bit,
		.rx_is_flow_char, .sw_flow_active, .rx_head, .tx_char, .tx_char_sent, .tx_serial,
		.auto_rts_en, .auto_rts_n, .bell_signal_in_n, .carrier_detect_in_n, .rx_store,
		.rx_parity_error, .resume_tx, .rx_pop, .tx_push, .tx_data, .tx_parity, .tx_line,
		.rx_flush, .tx_flush, .fifo_enable, .rx_request, .tx_request, .receive_ready_pin_n,
		.transmit_ready_pin_n, .line_cfg, .modem_pins, .loopback, .divisor,
		.divisor_fraction);
	uart_line_peer peer (.aclk, .rx_char_valid, .rx_char, .rx_parity_bit, .rx_is_flow_char,
		.sw_flow_active, .rx_head, .tx_char, .tx_char_sent, .tx_serial, .auto_rts_en,
		.auto_rts_n, .bell_signal_in_n, .carrier_detect_in_n);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk(bresp, er);
	endtask
	task rd(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk(rresp, er);
		chk(rdata, exp);
	endtask
	task summarize;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		summarize;
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk(modem_pins, 3'b111);
		rd(OFS_LINE, 0);
		rd(OFS_FIFO_SETUP, 0);
		wr(OFS_LINE, 32'h3f);
		rd(OFS_LINE, 32'h3f);
		wr(OFS_LINE, 32'h2b);
		chk(tx_parity, 1);
		wr(OFS_LINE, 32'h3b);
		chk(tx_parity, 0);
		wr(OFS_LINE, 32'h43);
		chk(tx_line, 0);
		wr(OFS_LINE, 32'h03);
		chk(tx_line, 1);
		wr(OFS_DIV_HIGH, 32'h12, RESP_SLVERR);
		wr(OFS_LINE, 32'h83);
		wr(OFS_DATA, 32'h34);
		wr(OFS_DIV_HIGH, 32'h12);
		chk(divisor, 16'h1234);
		wr(OFS_DIV_FRAC, 32'h05);
		chk(divisor_fraction, 8'h05);
		rd(OFS_DATA, 32'h34);
		wr(OFS_LINE, 32'h03);
		rd(OFS_DIV_HIGH, 32'h00, RESP_SLVERR);
		rd(6'h2c, 0, RESP_SLVERR);
		wr(OFS_MODEM, 32'h14);
		rd(OFS_STATUS, 32'h0002_0000);
		wr(OFS_MODEM, 32'h1f);
		rd(OFS_MODEM, 32'h1f);
		rd(OFS_STATUS, 32'h0006_0000);
		chk(modem_pins, 3'b111);
		wr(OFS_MODEM, 32'h03);
		chk(modem_pins, 3'b001);
		wr(OFS_MODEM, 32'h08);
		chk(modem_pins, 3'b110);
		wr(OFS_ALT, 32'h02);
		chk(modem_pins, 3'b111);
		wr(OFS_ALT, 32'h00);
		// Parity, storage and Xon-Any on single received characters
		wr(OFS_LINE, 32'h0b);
		peer.put(8'h07, 1'b1, 1'b0, 1'b0);
		chk(tx_parity, 0);
		chk(rx_parity_error, 1);
		chk(rx_store, 1);
		peer.send(0);
		wr(OFS_LINE, 32'h1b);
		peer.put(8'h07, 1'b1, 1'b1, 1'b1);
		chk(tx_parity, 1);
		chk(rx_parity_error, 0);
		chk(rx_store, 0);
		peer.send(0);
		wr(OFS_LINE, 32'h08);
		peer.put(8'he3, 1'b1, 1'b1, 1'b0);
		chk(tx_parity, 1);
		chk(rx_store, 1);
		peer.send(0);
		wr(OFS_LINE, 32'h03);
		wr(OFS_MODEM, 32'h20);
		peer.put(8'h07, 1'b1, 1'b0, 1'b0);
		chk(rx_parity_error, 0);
		chk(resume_tx, 0);
		peer.send(0);
		wr(OFS_ENH, 32'h10);
		peer.put(8'h41, 1'b0, 1'b0, 1'b0);
		chk(resume_tx, 1);
		peer.send(0);
		wr(OFS_ENH, 32'h00);
		wr(OFS_MODEM, 32'h00);
		// Each pass flushes, so a stale count would trip the first compare
		for (int i = 0; i < 13; i++) begin
			@(posedge aclk);
			wr(OFS_FEAT, 32'({TBL[i], 4'h0}));
			if (TBL[i] == 2'h3) wr(OFS_TRG, 32'(LVL[i]));
			wr(OFS_FIFO_SETUP, 32'({CODE[i], 6'h03}));
			repeat (2) @(posedge aclk);
			peer.send(LVL[i] - 1);
			chk(rx_request, 0);
			peer.send(1);
			chk(rx_request, 1);
			chk(receive_ready_pin_n, 0);
		end
		@(posedge aclk);
		// Reset bit without enable must leave the level alone
		wr(OFS_FIFO_SETUP, 32'h02);
		chk(fifo_enable, 0);
		rd(OFS_STATUS, 32'h03);
		rd(OFS_DATA, 32'h00);
		rd(OFS_STATUS, 32'h02);
		wr(OFS_FEAT, 32'h10);
		wr(OFS_FIFO_SETUP, 32'h17);
		repeat (2) @(posedge aclk);
		chk(tx_request, 1);
		wr(OFS_DATA, 0);
		chk(tx_request, 0);
		for (int i = 0; i < 16; i++) wr(OFS_DATA, i);
		chk(tx_data, 8'h0f);
		chk(transmit_ready_pin_n, 1);
		peer.take(1);
		chk(tx_request, 0);
		peer.take(1);
		chk(tx_request, 1);
		@(posedge aclk);
		wr(OFS_FIFO_SETUP, 32'h09);
		chk(transmit_ready_pin_n, 0);
		peer.send(1);
		chk(receive_ready_pin_n, 1);
		wr(OFS_ENH, 32'h10);
		wr(OFS_FIFO_SETUP, 32'h11);
		chk(tx_request, 0);
		summarize;
	end
endmodule
bind uart_fifo_line_modem_control uart_cfg_checker cfg_chk (.aclk, .aresetn, .awaddr,
	.awvalid, .awready, .wdata, .wstrb, .tx_serial, .tx_line, .tx_parity, .rx_flush,
	.tx_flush, .line_cfg, .modem_pins, .loopback, .auto_rts_en);
